//--- link_partner_model.sv
`timescale 1ns/1ns
`default_nettype none

module link_partner_model (
    input  wire logic                                   i_clk,          // RX SerDes clock
    output logic [3:0]                                  o_frame_marker, // Frame marker seen
    output logic [3:0]                                  o_sync_lost,    // Frame sync lost
    output logic [3:0]                                  o_lane_trained, // Both ends ready
    output link_training_status_pkg::frame_decode_t [3:0] o_frame       // Decoded frames
);
    import link_training_status_pkg::*;

    // ==========================================================
    // Quiet line state at time zero
    initial begin
        o_frame_marker = 4'h0;
        o_sync_lost    = 4'h0;
        o_lane_trained = 4'h0;
        o_frame        = '0;
    end

    // ==========================================================
    // One frame: marker high one cycle, then low (needs low gap)
    task automatic send_frame(input int l, input partner_fields_t f);
        @(posedge i_clk);
        o_frame_marker[l] <= 1'b1;
        o_frame[l]        <= {1'b1, f};
        @(posedge i_clk);
        o_frame_marker[l] <= 1'b0;
        // Stale fields flipped so a missing hold cannot pass
        o_frame[l]        <= {1'b0, ~f};
    endtask

    // Sync loss pulse of one cycle
    task automatic lose_sync(input int l);
        @(posedge i_clk);
        o_sync_lost[l] <= 1'b1;
        @(posedge i_clk);
        o_sync_lost[l] <= 1'b0;
    endtask

    task automatic set_trained(input int l);
        @(posedge i_clk);
        o_lane_trained[l] <= 1'b1;
    endtask
endmodule

`default_nettype wire

//--- link_training_status.sv
// Function
// - Per lane, flag set once training machine reaches data-sending state.
// - Per lane, in-training level high while machine performs training.
// - Per lane, failure flag set when training period times out.
// - Per lane, frame-start output pulses exactly one clock per received frame.
// - After training begins, frame-lock asserts when receiver syncs to partner frames.
// - Per lane, present partner's preset request bit from latest control block.
// - Per lane, present partner's initialize request bit from control block.
// - Per lane, three 2-bit fields of received post, main, pre update requests.
// - Per lane, three 2-bit fields of partner's post, main, pre update status.
// - Single output reflecting receive CDR hold from negotiation logic.
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module link_training_status #(
    parameter int TRAIN_WAIT = link_training_status_pkg::TRAIN_WAIT_CYC
) (
    input  wire logic                                   i_clk,          // RX SerDes clock
    input  wire logic                                   i_reset,        // Sync reset, high
    input  wire logic [1:0]                             i_htrans,       // AHB transfer type
    input  wire logic                                   i_hsel,         // AHB select
    input  wire logic [7:0]                             i_haddr,        // AHB address
    input  wire logic                                   i_hwrite,       // AHB write
    input  wire logic [2:0]                             i_hsize,        // AHB size
    input  wire logic [31:0]                            i_hwdata,       // AHB write data
    input  wire logic                                   i_hready,       // AHB bus ready
    output logic                                        o_hreadyout,    // Always ready
    output logic                                        o_hresp,        // Always OKAY
    output logic [31:0]                                 o_hrdata,       // Read data
    input  wire logic [3:0]                             i_frame_marker, // Frame marker seen
    input  wire logic [3:0]                             i_sync_lost,    // Frame sync lost
    input  wire logic [3:0]                             i_lane_trained, // Both ends ready
    input  wire link_training_status_pkg::frame_decode_t [3:0] i_frame, // Decoded frames
    input  wire logic                                   i_cdr_hold,     // From negotiation
    output logic [3:0]                                  o_lane_training_done, // Data state
    output logic [3:0]                                  o_lane_in_training, // Training
    output logic [3:0]                                  o_lane_training_timeout, // Timed out
    output logic [3:0]                                  o_train_frame_start_pulse, // Start pulse
    output logic [3:0]                                  o_train_frame_locked, // Frame lock
    output link_training_status_pkg::partner_fields_t [3:0] o_partner, // Partner fields
    output logic                                        o_recv_cdr_hold, // CDR hold
    output logic                                        o_irq           // Level interrupt
);
    import link_training_status_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        lane_state_t     st;
        logic [TMR_W-1:0] tmr;
        logic            marker_prev;
        logic            sof_pulse;
        logic            locked;
        partner_fields_t fields;
    } lane_t;

    typedef struct packed {
        lane_t [NUM_LANES-1:0] lane;
        logic [3:0]            enable;
        logic [EVT_W-1:0]      irq_stat;
        logic [EVT_W-1:0]      irq_mask;
        logic                  cdr_hold;
        logic                  dp_write;
        logic [7:0]            dp_addr;
        logic [31:0]           rdata;
    } state_t;

    state_t r;
    state_t next_r;

    logic [EVT_W-1:0] events;
    logic [EVT_W-1:0] w1c;
    logic             addr_phase;
    logic [31:0]      status_word;

    localparam logic [TMR_W-1:0] WAIT_LAST = TMR_W'(TRAIN_WAIT - 1);

    // Only whole-word transfers are taken; narrower sizes fall through as idle
    assign addr_phase = i_hsel && i_htrans[1] && i_hready && (i_hsize == 3'b010);

    // ==========================================================
    // Next state
    always_comb begin
        next_r      = r;
        events      = '0;
        w1c         = '0;
        status_word = DATA_ZERO;

        // Per-lane training progress, framing and field capture
        for (int l = 0; l < NUM_LANES; l++) begin
            next_r.lane[l].marker_prev = i_frame_marker[l];
            next_r.lane[l].sof_pulse   = i_frame_marker[l] && !r.lane[l].marker_prev;
            if (!r.enable[l]) begin
                next_r.lane[l].st  = LANE_IDLE;
                next_r.lane[l].tmr = '0;
            end else begin
                unique case (r.lane[l].st)
                    LANE_IDLE: begin
                        next_r.lane[l].st  = LANE_TRAIN;
                        next_r.lane[l].tmr = '0;
                    end
                    LANE_TRAIN: begin
                        if (i_lane_trained[l]) begin
                            next_r.lane[l].st = LANE_DONE;
                        end else if (r.lane[l].tmr == WAIT_LAST) begin
                            next_r.lane[l].st = LANE_FAIL;
                        end else begin
                            next_r.lane[l].tmr = r.lane[l].tmr + TMR_W'(1);
                        end
                    end
                    LANE_DONE: begin
                        next_r.lane[l].st = LANE_DONE;
                    end
                    LANE_FAIL: begin
                        next_r.lane[l].st = LANE_FAIL;
                    end
                endcase
            end
            // Lock only counts once training has started; idle drops it
            if (r.lane[l].st == LANE_IDLE || i_sync_lost[l]) begin
                next_r.lane[l].locked = 1'b0;
            end else if (i_frame_marker[l] && !r.lane[l].marker_prev) begin
                next_r.lane[l].locked = 1'b1;
            end
            // Fields move only on a whole decoded frame
            if (i_frame[l].valid) begin
                next_r.lane[l].fields = i_frame[l].fields;
            end
            // Events compare next and current copies, so each edge counts once
            events[EV_DONE_LSB + l] = next_r.lane[l].st == LANE_DONE
                                      && r.lane[l].st != LANE_DONE;
            events[EV_FAIL_LSB + l] = next_r.lane[l].st == LANE_FAIL
                                      && r.lane[l].st != LANE_FAIL;
            events[EV_LOCK_LSB + l] = next_r.lane[l].locked && !r.lane[l].locked;
            events[EV_LOSS_LSB + l] = !next_r.lane[l].locked && r.lane[l].locked;
        end

        // One register stage cuts the path back into the negotiation logic
        next_r.cdr_hold = i_cdr_hold;

        // Data phase write; a set in the same cycle beats the clear
        if (r.dp_write) begin
            unique case (r.dp_addr)
                ADDR_CTRL:     next_r.enable   = i_hwdata[3:0];
                ADDR_IRQ_STAT: w1c             = i_hwdata[EVT_W-1:0];
                ADDR_IRQ_MASK: next_r.irq_mask = i_hwdata[EVT_W-1:0];
                default:       next_r.enable   = r.enable;
            endcase
        end
        next_r.irq_stat = (r.irq_stat & ~w1c) | events;

        // Address phase capture and read mux from the updated copy
        next_r.dp_write = addr_phase && i_hwrite;
        next_r.dp_addr  = addr_phase ? {i_haddr[7:2], 2'b00} : r.dp_addr;
        for (int l = 0; l < NUM_LANES; l++) begin
            status_word[ST_TRAIN_LSB + l] = next_r.lane[l].st == LANE_TRAIN;
            status_word[ST_DONE_LSB + l]  = next_r.lane[l].st == LANE_DONE;
            status_word[ST_FAIL_LSB + l]  = next_r.lane[l].st == LANE_FAIL;
            status_word[ST_LOCK_LSB + l]  = next_r.lane[l].locked;
        end
        status_word[ST_CDR_BIT] = next_r.cdr_hold;
        next_r.rdata = DATA_ZERO;
        if (addr_phase && !i_hwrite) begin
            if (i_haddr[7:2] == ADDR_CTRL[7:2]) begin
                next_r.rdata = {28'h000_0000, next_r.enable};
            end else if (i_haddr[7:2] == ADDR_STATUS[7:2]) begin
                next_r.rdata = status_word;
            end else if (i_haddr[7:2] == ADDR_IRQ_STAT[7:2]) begin
                next_r.rdata = {16'h0000, next_r.irq_stat};
            end else if (i_haddr[7:2] == ADDR_IRQ_MASK[7:2]) begin
                next_r.rdata = {16'h0000, next_r.irq_mask};
            end else if (i_haddr >= ADDR_FIELDS0 && i_haddr <= ADDR_LAST + 8'h03) begin
                next_r.rdata = {18'h0_0000, next_r.lane[i_haddr[3:2]].fields};
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            r          <= '0;
            r.enable   <= CTRL_RESET;
            r.irq_mask <= MASK_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs, zero-wait slave
    assign o_hreadyout     = 1'b1;
    assign o_hresp         = 1'b0;
    assign o_hrdata        = r.rdata;
    assign o_recv_cdr_hold = r.cdr_hold;
    assign o_irq           = |(r.irq_stat & r.irq_mask);

    // Lane outputs straight from lane state
    always_comb begin
        for (int l = 0; l < NUM_LANES; l++) begin
            o_lane_training_done[l]      = r.lane[l].st == LANE_DONE;
            o_lane_in_training[l]        = r.lane[l].st == LANE_TRAIN;
            o_lane_training_timeout[l]   = r.lane[l].st == LANE_FAIL;
            o_train_frame_start_pulse[l] = r.lane[l].sof_pulse;
            o_train_frame_locked[l]      = r.lane[l].locked;
            o_partner[l]                 = r.lane[l].fields;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    for (genvar g = 0; g < NUM_LANES; g++) begin : g_chk
        chk_sof_single_pulse: assert property (
            o_train_frame_start_pulse[g] |=> !o_train_frame_start_pulse[g])
            else $error("frame start pulse longer than one cycle");
        chk_sof_from_marker: assert property (
            i_frame_marker[g] && !$past(i_frame_marker[g]) |=> o_train_frame_start_pulse[g])
            else $error("frame start pulse missing");
        chk_done_after_train: assert property (
            o_lane_in_training[g] && i_lane_trained[g] && r.enable[g]
            |=> o_lane_training_done[g])
            else $error("lane did not reach data state");
        chk_train_starts: assert property (
            r.enable[g] && r.lane[g].st == LANE_IDLE |=> o_lane_in_training[g])
            else $error("training did not start");
        chk_timeout_sets: assert property (
            o_lane_in_training[g] && r.enable[g] && !i_lane_trained[g]
            && r.lane[g].tmr == WAIT_LAST |=> o_lane_training_timeout[g])
            else $error("timeout not flagged");
        chk_lock_needs_train: assert property (
            o_train_frame_locked[g] |-> $past(r.lane[g].st) != LANE_IDLE)
            else $error("lock outside training");
        chk_fields_load: assert property (
            i_frame[g].valid |=> o_partner[g] == $past(i_frame[g].fields))
            else $error("partner fields not loaded");
        chk_fields_hold: assert property (
            !i_frame[g].valid |=> $stable(o_partner[g]))
            else $error("partner fields changed between frames");

        // Terminal states hold while the lane stays enabled
        chk_done_holds: assert property (
            o_lane_training_done[g] && r.enable[g] |=> o_lane_training_done[g])
            else $error("data state left while enabled");
        chk_fail_holds: assert property (
            o_lane_training_timeout[g] && r.enable[g] |=> o_lane_training_timeout[g])
            else $error("timeout flag dropped while enabled");
        chk_timer_bounded: assert property (
            o_lane_in_training[g] |-> r.lane[g].tmr <= WAIT_LAST)
            else $error("training timer ran past its limit");

        // A disabled lane falls back to idle with its training, done and timeout flags low
        chk_disable_idles: assert property (
            !r.enable[g] |=> !o_lane_in_training[g] && !o_lane_training_done[g]
            && !o_lane_training_timeout[g])
            else $error("disabled lane not idle");

        // Frame start only ever follows a marker
        chk_sof_needs_marker: assert property (
            !i_frame_marker[g] |=> !o_train_frame_start_pulse[g])
            else $error("frame start pulse without marker");

        // Lock comes with a fresh marker in training; sync loss always clears it
        chk_lock_gain: assert property (
            o_lane_in_training[g] && !i_sync_lost[g] && i_frame_marker[g]
            && !$past(i_frame_marker[g]) |=> o_train_frame_locked[g])
            else $error("frame lock not gained");
        chk_lock_loss: assert property (
            i_sync_lost[g] |=> !o_train_frame_locked[g])
            else $error("frame lock kept after sync loss");

        // Each done, timeout and lock edge leaves its sticky event bit set
        chk_done_event_sets: assert property (
            $rose(o_lane_training_done[g]) |-> r.irq_stat[EV_DONE_LSB + g])
            else $error("done event not recorded");
        chk_fail_event_sets: assert property (
            $rose(o_lane_training_timeout[g]) |-> r.irq_stat[EV_FAIL_LSB + g])
            else $error("timeout event not recorded");
        chk_lock_event_sets: assert property (
            $rose(o_train_frame_locked[g]) |-> r.irq_stat[EV_LOCK_LSB + g])
            else $error("lock event not recorded");
        chk_loss_event_sets: assert property (
            $fell(o_train_frame_locked[g]) |-> r.irq_stat[EV_LOSS_LSB + g])
            else $error("lock loss event not recorded");
    end

    chk_cdr_follow: assert property (
        ##1 o_recv_cdr_hold == $past(i_cdr_hold))
        else $error("cdr hold not reflected");

    // Read data stands only in the data phase of a read, zero otherwise
    chk_rdata_idle_zero: assert property (
        !(addr_phase && !i_hwrite) |=> o_hrdata == DATA_ZERO)
        else $error("read data outside a read data phase");

endmodule

`default_nettype wire

//--- link_training_status_pkg.sv
`default_nettype none

package link_training_status_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_LANES = 4;
    localparam int EVT_W     = 16;
    localparam int TMR_W     = 24;

    // ==========================================================
    // Timing
    localparam int CLK_HZ         = 20_000_000;
    localparam int TRAIN_WAIT_MS  = 500;
    localparam int TRAIN_WAIT_CYC = TRAIN_WAIT_MS * (CLK_HZ / 1000);

    // ==========================================================
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_FIELDS0  = 8'h10;
    localparam logic [7:0] ADDR_LAST     = 8'h1C;

    // ==========================================================
    // Field positions
    localparam int ST_TRAIN_LSB = 0;
    localparam int ST_DONE_LSB  = 4;
    localparam int ST_FAIL_LSB  = 8;
    localparam int ST_LOCK_LSB  = 12;
    localparam int ST_CDR_BIT   = 16;
    localparam int EV_DONE_LSB  = 0;
    localparam int EV_FAIL_LSB  = 4;
    localparam int EV_LOCK_LSB  = 8;
    localparam int EV_LOSS_LSB  = 12;

    // ==========================================================
    // Reset values
    localparam logic [3:0]       CTRL_RESET = 4'h0;
    localparam logic [EVT_W-1:0] MASK_RESET = 16'h0000;
    localparam logic [31:0]      DATA_ZERO  = 32'h0000_0000;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        LANE_IDLE  = 2'b00,
        LANE_TRAIN = 2'b01,
        LANE_DONE  = 2'b11,
        LANE_FAIL  = 2'b10
    } lane_state_t;

    typedef struct packed {
        logic       preset_req;
        logic       init_req;
        logic [1:0] post_tap_req;
        logic [1:0] main_tap_req;
        logic [1:0] pre_tap_req;
        logic [1:0] post_tap_status;
        logic [1:0] main_tap_status;
        logic [1:0] pre_tap_status;
    } partner_fields_t;

    typedef struct packed {
        logic            valid;
        partner_fields_t fields;
    } frame_decode_t;

endpackage

`default_nettype wire

//--- tb_link_training_status.sv
`timescale 1ns/1ns
`default_nettype none

module tb_link_training_status;
    import link_training_status_pkg::*;

    // ==========================================================
    // Signals
    localparam int TW = 100;
    logic i_clk = 1'b0, i_reset = 1'b1, i_hsel = 1'b0, i_hwrite = 1'b0, i_cdr_hold = 1'b0;
    logic [1:0] i_htrans = 2'b00;
    logic [7:0] i_haddr = 8'h00;
    logic [31:0] i_hwdata = 32'h0000_0000, d;
    logic o_hreadyout, o_hresp, o_irq, o_recv_cdr_hold;
    logic [31:0] o_hrdata;
    logic [3:0] mk, sl, tr, o_done, o_intr, o_tmo, o_sof, o_lock;
    frame_decode_t [3:0] fr;
    partner_fields_t [3:0] o_partner;
    partner_fields_t vals [2] = '{14'h26e4, 14'h1b1b};
    int err_total = 0, check_count = 0;

    // 20 MHz clock
    always #25 i_clk = ~i_clk;

    link_training_status #(.TRAIN_WAIT(TW)) link_training_status_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_htrans(i_htrans), .i_hsel(i_hsel),
        .i_haddr(i_haddr), .i_hwrite(i_hwrite), .i_hsize(3'b010), .i_hwdata(i_hwdata),
        .i_hready(o_hreadyout), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
        .o_hrdata(o_hrdata), .i_frame_marker(mk), .i_sync_lost(sl), .i_lane_trained(tr),
        .i_frame(fr), .i_cdr_hold(i_cdr_hold), .o_lane_training_done(o_done),
        .o_lane_in_training(o_intr), .o_lane_training_timeout(o_tmo),
        .o_train_frame_start_pulse(o_sof), .o_train_frame_locked(o_lock),
        .o_partner(o_partner), .o_recv_cdr_hold(o_recv_cdr_hold), .o_irq(o_irq));

    link_partner_model link_partner_model_i (
        .i_clk(i_clk), .o_frame_marker(mk), .o_sync_lost(sl), .o_lane_trained(tr),
        .o_frame(fr));

    // ==========================================================
    // Bus and check tasks; the bus transfers start on a fresh edge, check compares at once
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic ahb_xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge i_clk);
        i_hsel   <= 1'b1;
        i_htrans <= 2'b10;
        i_haddr  <= a;
        i_hwrite <= w;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        i_htrans <= 2'b00;
        i_hwdata <= wd;
        do @(posedge i_clk); while (o_hreadyout !== 1'b1);
        // Read data taken at the edge that ends the data phase
        d = o_hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        ahb_xfer(a, 1'b0, 32'h0000_0000);
        check(d, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        repeat (3000) @(posedge i_clk);
        err_total++;
        print_verdict();
    end

    // ==========================================================
    // Main sequence
    initial begin
        repeat (16) @(posedge i_clk);
        i_reset <= 1'b0;
        tick(1);
        check({o_hreadyout, o_hresp, o_irq, o_intr, o_lock, o_recv_cdr_hold, o_done, o_tmo,
               o_sof}, 32'h0080_0000);
        check(o_partner[3:2], DATA_ZERO);
        check(o_partner[1:0], DATA_ZERO);
        rd_chk(ADDR_CTRL, {28'h000_0000, CTRL_RESET});
        rd_chk(ADDR_IRQ_MASK, {16'h0000, MASK_RESET});
        rd_chk(ADDR_STATUS, DATA_ZERO);
        ahb_xfer(ADDR_CTRL, 1'b1, 32'h0000_0001);
        tick(3);
        check(o_intr, 4'h1);
        // Two frames: outputs follow the newest, then hold
        foreach (vals[k]) begin
            link_partner_model_i.send_frame(0, vals[k]);
            #1;
            check(o_sof[0], 1'b1);
            check(o_lock[0], 1'b1);
            check(o_partner[0].preset_req, vals[k].preset_req);
            check(o_partner[0].init_req, vals[k].init_req);
            check(o_partner[0][11:6], vals[k][11:6]);
            check(o_partner[0][5:0], vals[k][5:0]);
            tick(1);
            check(o_sof[0], 1'b0);
            check(o_partner[0], vals[k]);
        end
        rd_chk(ADDR_FIELDS0, {18'h0_0000, vals[1]});
        // Lock is refused on an idle lane
        link_partner_model_i.send_frame(1, vals[0]);
        tick(1);
        check(o_lock[1], 1'b0);
        check(o_partner[1], vals[0]);
        link_partner_model_i.set_trained(0);
        tick(2);
        check({o_done[0], o_intr[0]}, 2'b10);
        rd_chk(ADDR_STATUS, (32'h1 << ST_DONE_LSB) | (32'h1 << ST_LOCK_LSB));
        rd_chk(ADDR_IRQ_STAT, (32'h1 << EV_DONE_LSB) | (32'h1 << EV_LOCK_LSB));
        check(o_irq, 1'b0);
        // Unmask, then clear by writing ones
        ahb_xfer(ADDR_IRQ_MASK, 1'b1, 32'h0000_0001);
        tick(1);
        check(o_irq, 1'b1);
        ahb_xfer(ADDR_IRQ_STAT, 1'b1, 32'h0000_ffff);
        tick(1);
        check(o_irq, 1'b0);
        rd_chk(ADDR_IRQ_STAT, DATA_ZERO);
        link_partner_model_i.lose_sync(0);
        tick(1);
        check(o_lock[0], 1'b0);
        rd_chk(ADDR_IRQ_STAT, 32'h1 << EV_LOSS_LSB);
        // Lane 2 left without partner ready runs into the timer
        ahb_xfer(ADDR_CTRL, 1'b1, 32'h0000_0005);
        tick(TW / 2);
        check({o_tmo[2], o_intr[2]}, 2'b01);
        tick(TW / 2 + 5);
        check({o_tmo[2], o_intr[2]}, 2'b10);
        rd_chk(ADDR_IRQ_STAT, (32'h1 << EV_LOSS_LSB) | (32'h1 << (EV_FAIL_LSB + 2)));
        @(posedge i_clk);
        i_cdr_hold <= 1'b1;
        tick(1);
        check(o_recv_cdr_hold, 1'b1);
        rd_chk(ADDR_STATUS, (32'h1 << ST_CDR_BIT) | (32'h1 << ST_DONE_LSB)
               | (32'h1 << (ST_FAIL_LSB + 2)));
        // Clearing the enables sends every lane back to idle
        ahb_xfer(ADDR_CTRL, 1'b1, DATA_ZERO);
        tick(2);
        check({o_done, o_tmo, o_intr}, DATA_ZERO);
        // Unmapped place reads zero
        rd_chk(8'h20, DATA_ZERO);
        print_verdict();
    end
endmodule

`default_nettype wire
